// >>> hw/edad_pkg.sv
// Shared constants and types for energy detection and antenna diversity
package edad_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] ADDR_CONV_CLK = 8'h08;
  localparam logic [7:0] ADDR_ENERGY_RESULT = 8'h16;
  localparam logic [7:0] ADDR_ENERGY_CTRL = 8'h1B;
  localparam logic [7:0] ADDR_DIV_AVG = 8'h6D;
  localparam logic [7:0] ADDR_DIV_CTRL = 8'h71;
  localparam logic [7:0] ADDR_ANT_ONE_ENERGY = 8'h73;
  localparam logic [7:0] ADDR_ANT_TWO_ENERGY = 8'h74;
  localparam logic [7:0] ADDR_PIN_FORCE = 8'h75;

  // ==========================================================
  // Field positions
  localparam int BIT_CONV_FAST = 4;
  localparam int BIT_CALC_EN = 7;
  localparam int BIT_AVG_DONE = 4;
  localparam int AVG_LSB = 0;
  localparam int AVG_W = 3;
  localparam int BIT_DIV_EN = 0;
  localparam int BIT_DOUBLE_THROW = 1;
  localparam int BIT_TRX_INV = 2;
  localparam int BIT_POL_MODE = 5;
  localparam int BIT_TRX_FORCE_EN = 0;
  localparam int BIT_ANT_FORCE_EN = 1;
  localparam int BIT_TRX_FORCE_VAL = 4;
  localparam int BIT_ANT_FORCE_VAL = 5;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_REG = 8'h00;

  // ==========================================================
  // Timing
  localparam int CLK_NS = 4;
  localparam int CONV_SLOW_NS = 17700;
  localparam int CONV_FAST_NS = 16000;
  localparam int CONV_SLOW_CYC = CONV_SLOW_NS / CLK_NS;
  localparam int CONV_FAST_CYC = CONV_FAST_NS / CLK_NS;
  localparam int CNT_W = 16;

  // ==========================================================
  // Types
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
  } edad_reg_req_type;

  typedef struct packed {
    logic antenna_select;
    logic transmit_receive;
  } edad_pins_type;

  typedef enum logic [2:0] {
    DV_OFF,
    DV_WAIT,
    DV_ANT_A,
    DV_ANT_B,
    DV_LOCK
  } edad_div_state_type;

endpackage : edad_pkg

// >>> hw/edad_top.sv
// Energy averaging, two-antenna diversity and antenna switch pin drive
// ==========================================================
module edad_top #(
  parameter int CONV_SLOW_CYCLES = edad_pkg::CONV_SLOW_CYC
) (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire edad_pkg::edad_reg_req_type reg_req_in,
  output logic [7:0] reg_rdata_out,
  input wire logic rx_on_in,
  input wire logic tx_on_in,
  input wire logic [7:0] rssi_in,
  input wire logic cca_busy_in,
  input wire logic gain_switch_in,
  input wire logic data_detect_in,
  input wire logic preamble_detect_in,
  input wire logic search_timer_expired_in,
  input wire logic div_int_clear_in,
  input wire logic rx_int_clear_in,
  output logic div_done_out,
  output logic div_false_out,
  output logic antenna_select_pin_out,
  output logic transmit_receive_pin_out
);

  // ==========================================================
  // Register storage
  logic [7:0] conv_clk_reg;
  logic [7:0] energy_ctrl;
  logic [7:0] div_avg_reg;
  logic [7:0] div_ctrl;
  logic [7:0] pin_force;
  logic [7:0] energy_result;
  logic [7:0] ant_one_energy;
  logic [7:0] ant_two_energy;
  logic energy_average_complete;
  logic chosen_ant_two;

  logic energy_calc_enable;
  logic diversity_enable;
  logic double_throw_select;
  logic trx_pin_invert;
  logic antenna_polarity_mode;
  logic [2:0] average_count_field;
  logic [2:0] diversity_average_count;

  assign energy_calc_enable = energy_ctrl[edad_pkg::BIT_CALC_EN];
  assign average_count_field =
    energy_ctrl[edad_pkg::AVG_LSB +: edad_pkg::AVG_W];
  assign diversity_average_count =
    div_avg_reg[edad_pkg::AVG_LSB +: edad_pkg::AVG_W];
  assign diversity_enable = div_ctrl[edad_pkg::BIT_DIV_EN];
  assign double_throw_select = div_ctrl[edad_pkg::BIT_DOUBLE_THROW];
  assign trx_pin_invert = div_ctrl[edad_pkg::BIT_TRX_INV];
  assign antenna_polarity_mode = div_ctrl[edad_pkg::BIT_POL_MODE];

  // ==========================================================
  // Diversity state
  edad_pkg::edad_div_state_type div_state;
  logic searching;
  logic preamble_seen;
  logic false_recent;
  logic skip_next;
  logic div_run;

  assign searching = (div_state == edad_pkg::DV_WAIT) ||
    (div_state == edad_pkg::DV_ANT_A) || (div_state == edad_pkg::DV_ANT_B);
  assign div_run = diversity_enable && rx_on_in;

  // ==========================================================
  // Conversion tick divider
  localparam logic [edad_pkg::CNT_W-1:0] SLOW_LAST =
    edad_pkg::CNT_W'(CONV_SLOW_CYCLES - 1);
  localparam logic [edad_pkg::CNT_W-1:0] FAST_LAST =
    edad_pkg::CNT_W'(edad_pkg::CONV_FAST_CYC - 1);
  logic [edad_pkg::CNT_W-1:0] conv_cnt;
  logic [edad_pkg::CNT_W-1:0] conv_last;
  logic conv_tick;
  logic restart;

  assign conv_last = conv_clk_reg[edad_pkg::BIT_CONV_FAST] ?
    FAST_LAST : SLOW_LAST;
  assign conv_tick = (conv_cnt == conv_last);

  // Restarted with each average so the first sample is a full period
  always_ff @(posedge sys_clk_in) begin
    if (srst_in || restart || conv_tick) begin
      conv_cnt <= '0;
    end else begin
      conv_cnt <= conv_cnt + 1'b1;
    end
  end

  // ==========================================================
  // Averaging engine
  logic acq_run;
  logic acq_prev;
  logic base_restart;
  logic avg_due;
  logic ant_swap;
  logic [2:0] avg_shift;
  logic [7:0] avg_last;
  logic [7:0] sample_cnt;
  logic [14:0] acc;
  logic [14:0] next_acc;
  logic avg_fire;
  logic [7:0] avg_value;

  // Diversity may measure even with calc enable clear
  assign acq_run = rx_on_in && !cca_busy_in &&
    (energy_calc_enable || searching);
  assign avg_shift = (div_state == edad_pkg::DV_ANT_A ||
    div_state == edad_pkg::DV_ANT_B) ?
    diversity_average_count : average_count_field;
  assign avg_last = 8'((9'h001 << avg_shift) - 9'h001);
  // Swap is built from the fire term, so it must not gate that term
  assign base_restart = gain_switch_in || (acq_run && !acq_prev);
  assign avg_due = acq_run && conv_tick && (sample_cnt == avg_last);
  assign avg_fire = avg_due && !base_restart;
  assign ant_swap = (div_state == edad_pkg::DV_ANT_A) && avg_fire;
  assign restart = base_restart || ant_swap;
  assign next_acc = acc + {7'h00, rssi_in};
  assign avg_value = 8'(next_acc >> avg_shift);

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      acq_prev <= 1'b0;
    end else begin
      acq_prev <= acq_run;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in || restart || !acq_run) begin
      acc <= '0;
      sample_cnt <= '0;
    end else if (conv_tick) begin
      if (sample_cnt == avg_last) begin
        acc <= '0;
        sample_cnt <= '0;
      end else begin
        acc <= next_acc;
        sample_cnt <= sample_cnt + 1'b1;
      end
    end
  end

  // Result and done flag
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      energy_result <= edad_pkg::RST_REG;
      energy_average_complete <= 1'b0;
    end else if (avg_fire && !searching) begin
      energy_result <= avg_value;
      energy_average_complete <= 1'b1;
    end else if (restart) begin
      energy_average_complete <= 1'b0;
    end
  end

  // ==========================================================
  // Diversity search
  logic div_clear;
  assign div_clear = div_int_clear_in || rx_int_clear_in || div_false_out;

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      div_state <= edad_pkg::DV_OFF;
      div_done_out <= 1'b0;
      div_false_out <= 1'b0;
      preamble_seen <= 1'b0;
    end else begin
      div_done_out <= 1'b0;
      div_false_out <= 1'b0;
      if (!div_run) begin
        div_state <= edad_pkg::DV_OFF;
      end else begin
        case (div_state)
          edad_pkg::DV_OFF: begin
            div_state <= skip_next ? edad_pkg::DV_LOCK
              : edad_pkg::DV_WAIT;
            preamble_seen <= 1'b0;
          end
          edad_pkg::DV_WAIT: begin
            if (data_detect_in) begin
              div_state <= edad_pkg::DV_ANT_A;
            end
          end
          edad_pkg::DV_ANT_A: begin
            if (avg_fire) begin
              div_state <= edad_pkg::DV_ANT_B;
            end
          end
          edad_pkg::DV_ANT_B: begin
            if (avg_fire) begin
              div_state <= edad_pkg::DV_LOCK;
              div_done_out <= 1'b1;
              preamble_seen <= 1'b0;
            end
          end
          edad_pkg::DV_LOCK: begin
            if (preamble_detect_in) begin
              preamble_seen <= 1'b1;
            end
            if (search_timer_expired_in && !preamble_seen &&
                !preamble_detect_in) begin
              div_state <= edad_pkg::DV_WAIT;
              div_false_out <= 1'b1;
            end else if (div_int_clear_in) begin
              div_state <= edad_pkg::DV_WAIT;
            end
          end
          default: begin
            div_state <= edad_pkg::DV_OFF;
          end
        endcase
      end
    end
  end

  // Skip bookkeeping after a false completion
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      false_recent <= 1'b0;
      skip_next <= 1'b0;
    end else begin
      if (div_false_out) begin
        false_recent <= 1'b1;
      end else if (preamble_detect_in || div_done_out) begin
        false_recent <= 1'b0;
      end
      if (tx_on_in && false_recent) begin
        skip_next <= 1'b1;
      end else if (div_state == edad_pkg::DV_OFF && div_run) begin
        skip_next <= 1'b0;
      end
    end
  end

  // Per-antenna energies; a new store wins over a clear
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      ant_one_energy <= edad_pkg::RST_REG;
      ant_two_energy <= edad_pkg::RST_REG;
      chosen_ant_two <= 1'b0;
    end else if (div_state == edad_pkg::DV_ANT_A && avg_fire) begin
      ant_one_energy <= avg_value;
    end else if (div_state == edad_pkg::DV_ANT_B && avg_fire) begin
      ant_two_energy <= avg_value;
      chosen_ant_two <= (avg_value > ant_one_energy);
    end else if (div_clear) begin
      ant_one_energy <= edad_pkg::RST_REG;
      ant_two_energy <= edad_pkg::RST_REG;
      chosen_ant_two <= 1'b0;
    end
  end

  // ==========================================================
  // Pin drive
  edad_pkg::edad_pins_type next_pins;
  logic use_ant_two;

  assign use_ant_two = (div_state == edad_pkg::DV_ANT_B) ||
    (div_state == edad_pkg::DV_LOCK && chosen_ant_two);

  always_comb begin
    next_pins = '0;
    if (double_throw_select && !antenna_polarity_mode) begin
      if (tx_on_in) begin
        next_pins = '{antenna_select: 1'b0, transmit_receive: 1'b1};
      end else if (rx_on_in && use_ant_two) begin
        next_pins = '{antenna_select: 1'b0, transmit_receive: 1'b1};
      end else begin
        next_pins = '{antenna_select: 1'b1, transmit_receive: 1'b0};
      end
      if (trx_pin_invert) begin
        next_pins = ~next_pins;
      end
    end else begin
      next_pins.antenna_select = rx_on_in && use_ant_two;
      next_pins.transmit_receive = tx_on_in ^ trx_pin_invert;
    end
    // Forcing is blocked during receive to keep the link in step
    if (!diversity_enable && !rx_on_in) begin
      if (pin_force[edad_pkg::BIT_ANT_FORCE_EN]) begin
        next_pins.antenna_select =
          pin_force[edad_pkg::BIT_ANT_FORCE_VAL];
      end
      if (pin_force[edad_pkg::BIT_TRX_FORCE_EN]) begin
        next_pins.transmit_receive = pin_force[edad_pkg::BIT_TRX_FORCE_VAL];
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      antenna_select_pin_out <= 1'b0;
      transmit_receive_pin_out <= 1'b0;
    end else begin
      antenna_select_pin_out <= next_pins.antenna_select;
      transmit_receive_pin_out <= next_pins.transmit_receive;
    end
  end

  // ==========================================================
  // Register port
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      conv_clk_reg <= edad_pkg::RST_REG;
      energy_ctrl <= edad_pkg::RST_REG;
      div_avg_reg <= edad_pkg::RST_REG;
      div_ctrl <= edad_pkg::RST_REG;
      pin_force <= edad_pkg::RST_REG;
    end else if (reg_req_in.wr) begin
      if (reg_req_in.addr == edad_pkg::ADDR_CONV_CLK) begin
        conv_clk_reg <= reg_req_in.wdata;
      end else if (reg_req_in.addr == edad_pkg::ADDR_ENERGY_CTRL) begin
        energy_ctrl <= reg_req_in.wdata;
      end else if (reg_req_in.addr == edad_pkg::ADDR_DIV_AVG) begin
        div_avg_reg <= reg_req_in.wdata;
      end else if (reg_req_in.addr == edad_pkg::ADDR_DIV_CTRL) begin
        div_ctrl <= reg_req_in.wdata;
      end else if (reg_req_in.addr == edad_pkg::ADDR_PIN_FORCE) begin
        pin_force <= reg_req_in.wdata;
      end
    end
  end

  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = 8'h00;
    if (reg_req_in.addr == edad_pkg::ADDR_CONV_CLK) begin
      next_rdata = conv_clk_reg;
    end else if (reg_req_in.addr == edad_pkg::ADDR_ENERGY_RESULT) begin
      next_rdata = energy_result;
    end else if (reg_req_in.addr == edad_pkg::ADDR_ENERGY_CTRL) begin
      next_rdata = energy_ctrl;
      next_rdata[edad_pkg::BIT_AVG_DONE] = energy_average_complete;
    end else if (reg_req_in.addr == edad_pkg::ADDR_DIV_AVG) begin
      next_rdata = div_avg_reg;
    end else if (reg_req_in.addr == edad_pkg::ADDR_DIV_CTRL) begin
      next_rdata = div_ctrl;
    end else if (reg_req_in.addr == edad_pkg::ADDR_ANT_ONE_ENERGY) begin
      next_rdata = ant_one_energy;
    end else if (reg_req_in.addr == edad_pkg::ADDR_ANT_TWO_ENERGY) begin
      next_rdata = ant_two_energy;
    end else if (reg_req_in.addr == edad_pkg::ADDR_PIN_FORCE) begin
      next_rdata = pin_force;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      reg_rdata_out <= 8'h00;
    end else begin
      reg_rdata_out <= next_rdata;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);

  done_set_a: assert property (avg_fire && !searching |=>
    energy_average_complete && energy_result == $past(avg_value))
    else $error("done flag or result not loaded");
  freeze_search_a: assert property (searching |=>
    $stable(energy_result))
    else $error("result changed during search");
  done_clear_a: assert property (gain_switch_in && !avg_fire |=>
    !energy_average_complete)
    else $error("gain switch left done set");
  eight_avg_a: assert property (
    average_count_field == 3'h3 && !searching |-> avg_last == 8'h07)
    else $error("count 011 not eight samples");
  div_start_a: assert property (
    div_state == edad_pkg::DV_OFF && div_run && !skip_next |=>
    div_state == edad_pkg::DV_WAIT)
    else $error("diversity did not start");
  false_restart_a: assert property (div_false_out |->
    div_state == edad_pkg::DV_WAIT ##1 ant_one_energy == 8'h00)
    else $error("false completion not recovered");
  clear_vals_a: assert property (rx_int_clear_in && !avg_fire |=>
    ant_one_energy == 8'h00 && ant_two_energy == 8'h00)
    else $error("antenna energies not cleared");
  dt_idle_a: assert property (
    double_throw_select && !antenna_polarity_mode && !trx_pin_invert &&
    !tx_on_in && !rx_on_in && !pin_force[edad_pkg::BIT_ANT_FORCE_EN] &&
    !pin_force[edad_pkg::BIT_TRX_FORCE_EN] |=>
    antenna_select_pin_out && !transmit_receive_pin_out)
    else $error("idle pin pair wrong");
  dt_invert_a: assert property (
    double_throw_select && !antenna_polarity_mode && trx_pin_invert &&
    tx_on_in && !rx_on_in && !pin_force[edad_pkg::BIT_ANT_FORCE_EN] &&
    !pin_force[edad_pkg::BIT_TRX_FORCE_EN] |=>
    antenna_select_pin_out && !transmit_receive_pin_out)
    else $error("inverted transmit pins wrong");
  skip_a: assert property (tx_on_in && false_recent |=> skip_next)
    else $error("skip not armed");

endmodule : edad_top

// >>> dv/edad_front_model.sv
// Behavioural antenna front end returning a per-antenna signal strength
module edad_front_model #(
  parameter logic [7:0] LEVEL_ONE = 8'h30,
  parameter logic [7:0] LEVEL_TWO = 8'h60
) (
  input wire logic sys_clk_in,
  input wire logic rx_on_in,
  input wire logic antenna_select_pin_in,
  output logic [7:0] rssi_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] noise = 8'h5A;

  // ==========================================================
  // Signal strength
  // Outside receive the level means nothing, so it wanders each cycle
  always @(posedge sys_clk_in) begin
    noise <= noise + 8'h35;
  end
  // Select pin high feeds antenna one in double-throw wiring
  assign rssi_out = !rx_on_in ? noise :
                    (antenna_select_pin_in ? LEVEL_ONE : LEVEL_TWO);
endmodule : edad_front_model

// >>> dv/edad_top_tb.sv
// Self-checking bench for energy averaging, diversity and switch pins
module edad_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk_in = 1'b0;
  logic srst_in = 1'b1;
  edad_pkg::edad_reg_req_type req = '0;
  logic [7:0] reg_rdata_out;
  logic rx_on_in = 1'b0;
  logic tx_on_in = 1'b0;
  logic [7:0] rssi;
  logic cca_busy_in = 1'b0;
  logic gain_switch_in = 1'b0;
  logic data_detect_in = 1'b0;
  logic search_timer_expired_in = 1'b0;
  logic preamble_detect_in = 1'b0;
  logic div_int_clear_in = 1'b0;
  logic rx_int_clear_in = 1'b0;
  logic div_done_out;
  logic div_false_out;
  logic ant_pin;
  logic trx_pin;
  int mismatches = 0;
  int checked = 0;

  edad_top #(.CONV_SLOW_CYCLES(8)) dut_u (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .reg_req_in(req),
    .reg_rdata_out(reg_rdata_out),
    .rx_on_in(rx_on_in),
    .tx_on_in(tx_on_in),
    .rssi_in(rssi),
    .cca_busy_in(cca_busy_in),
    .gain_switch_in(gain_switch_in),
    .data_detect_in(data_detect_in),
    .preamble_detect_in(preamble_detect_in),
    .search_timer_expired_in(search_timer_expired_in),
    .div_int_clear_in(div_int_clear_in),
    .rx_int_clear_in(rx_int_clear_in),
    .div_done_out(div_done_out),
    .div_false_out(div_false_out),
    .antenna_select_pin_out(ant_pin),
    .transmit_receive_pin_out(trx_pin)
  );

  edad_front_model front_u (
    .sys_clk_in(sys_clk_in),
    .rx_on_in(rx_on_in),
    .antenna_select_pin_in(ant_pin),
    .rssi_out(rssi)
  );

  // ==========================================================
  // Clock and tasks
  initial begin
    forever begin
      #2 sys_clk_in = ~sys_clk_in;
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic final_report();
    if (mismatches == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    #1;
    req.addr = a;
    req.wdata = d;
    req.wr = 1'b1;
    @(posedge sys_clk_in);
    #1;
    req.wr = 1'b0;
  endtask : wr

  // Read data follows the address one edge later
  task automatic rd(input logic [7:0] a, input logic [7:0] exp,
                    input string what);
    @(posedge sys_clk_in);
    #1;
    req.addr = a;
    @(posedge sys_clk_in);
    #1;
    check(reg_rdata_out, exp, what);
  endtask : rd

  task automatic pulse(ref logic s);
    @(posedge sys_clk_in);
    #1;
    s = 1'b1;
    @(posedge sys_clk_in);
    #1;
    s = 1'b0;
  endtask : pulse

  task automatic level(ref logic s, input logic v);
    @(posedge sys_clk_in);
    #1;
    s = v;
  endtask : level

  // Pins are registered, so allow their one-cycle lag
  task automatic pins(input logic ea, input logic et, input string what);
    repeat (2) @(posedge sys_clk_in);
    #1;
    check({6'h00, ant_pin, trx_pin}, {6'h00, ea, et}, what);
  endtask : pins

  // Bounded wait; the pulse may already stand when called
  task automatic wait_hi(ref logic s, input int lim, input string what);
    int n;
    n = 0;
    while (s !== 1'b1 && n < lim) begin
      @(posedge sys_clk_in);
      #1;
      n++;
    end
    check({7'h00, s}, 8'h01, what);
  endtask : wait_hi

  // ==========================================================
  // Tests
  initial begin
    logic [7:0] regs [8];
    regs = '{edad_pkg::ADDR_CONV_CLK, edad_pkg::ADDR_ENERGY_RESULT,
             edad_pkg::ADDR_ENERGY_CTRL, edad_pkg::ADDR_DIV_AVG,
             edad_pkg::ADDR_DIV_CTRL, edad_pkg::ADDR_ANT_ONE_ENERGY,
             edad_pkg::ADDR_ANT_TWO_ENERGY, edad_pkg::ADDR_PIN_FORCE};
    repeat (12) @(posedge sys_clk_in);
    #1;
    srst_in = 1'b0;
    foreach (regs[i]) begin
      rd(regs[i], edad_pkg::RST_REG, "reset value");
    end
    wr(edad_pkg::ADDR_DIV_AVG, 8'h05);
    rd(edad_pkg::ADDR_DIV_AVG, 8'h05, "rw register");
    wr(edad_pkg::ADDR_ENERGY_RESULT, 8'hFF);
    rd(edad_pkg::ADDR_ENERGY_RESULT, 8'h00, "read-only result");
    wr(8'h40, 8'hFF);
    rd(8'h40, 8'h00, "unmapped");
    wr(edad_pkg::ADDR_DIV_AVG, 8'h00);
    // Double-throw pin levels, plain and inverted
    wr(edad_pkg::ADDR_DIV_CTRL, 8'h02);
    pins(1'b1, 1'b0, "idle");
    level(tx_on_in, 1'b1);
    pins(1'b0, 1'b1, "transmit");
    wr(edad_pkg::ADDR_DIV_CTRL, 8'h06);
    pins(1'b1, 1'b0, "transmit inverted");
    level(tx_on_in, 1'b0);
    pins(1'b0, 1'b1, "idle inverted");
    // Forcing with diversity off and no receive
    wr(edad_pkg::ADDR_DIV_CTRL, 8'h00);
    wr(edad_pkg::ADDR_PIN_FORCE, 8'h33);
    pins(1'b1, 1'b1, "force both");
    wr(edad_pkg::ADDR_PIN_FORCE, 8'h22);
    pins(1'b1, 1'b0, "force select");
    wr(edad_pkg::ADDR_PIN_FORCE, 8'h00);
    wr(edad_pkg::ADDR_DIV_CTRL, 8'h02);
    pins(1'b1, 1'b0, "idle pins");
    // Energy average of one conversion, then eight
    wr(edad_pkg::ADDR_ENERGY_CTRL, 8'h80);
    level(rx_on_in, 1'b1);
    repeat (3) @(posedge sys_clk_in);
    rd(edad_pkg::ADDR_ENERGY_CTRL, 8'h80, "not done early");
    repeat (6) @(posedge sys_clk_in);
    rd(edad_pkg::ADDR_ENERGY_CTRL, 8'h90, "done one period");
    rd(edad_pkg::ADDR_ENERGY_RESULT, 8'h30, "result");
    pulse(gain_switch_in);
    rd(edad_pkg::ADDR_ENERGY_CTRL, 8'h80, "gain clears done");
    repeat (12) @(posedge sys_clk_in);
    rd(edad_pkg::ADDR_ENERGY_CTRL, 8'h90, "refresh");
    wr(edad_pkg::ADDR_ENERGY_CTRL, 8'h83);
    pulse(gain_switch_in);
    repeat (50) @(posedge sys_clk_in);
    rd(edad_pkg::ADDR_ENERGY_CTRL, 8'h83, "eight pending");
    repeat (20) @(posedge sys_clk_in);
    rd(edad_pkg::ADDR_ENERGY_CTRL, 8'h93, "eight done");
    rd(edad_pkg::ADDR_ENERGY_RESULT, 8'h30, "eight result");
    pulse(cca_busy_in);
    rd(edad_pkg::ADDR_ENERGY_CTRL, 8'h83, "resume clears");
    pins(1'b1, 1'b0, "receive pins");
    wr(edad_pkg::ADDR_PIN_FORCE, 8'h33);
    pins(1'b1, 1'b0, "no force in receive");
    wr(edad_pkg::ADDR_PIN_FORCE, 8'h00);
    level(rx_on_in, 1'b0);
    // Diversity picks the stronger antenna two
    wr(edad_pkg::ADDR_ENERGY_CTRL, 8'h80);
    wr(edad_pkg::ADDR_DIV_CTRL, 8'h03);
    level(rx_on_in, 1'b1);
    pins(1'b1, 1'b0, "diversity wait");
    pulse(data_detect_in);
    wait_hi(div_done_out, 100, "diversity done");
    pins(1'b0, 1'b1, "hold antenna two");
    rd(edad_pkg::ADDR_ANT_ONE_ENERGY, 8'h30, "antenna one");
    rd(edad_pkg::ADDR_ANT_TWO_ENERGY, 8'h60, "antenna two");
    pulse(search_timer_expired_in);
    wait_hi(div_false_out, 3, "false completion");
    rd(edad_pkg::ADDR_ANT_ONE_ENERGY, 8'h00, "one cleared");
    rd(edad_pkg::ADDR_ANT_TWO_ENERGY, 8'h00, "two cleared");
    pins(1'b1, 1'b0, "search again");
    // Preamble keeps the lock; a joint clear restarts the search
    pulse(data_detect_in);
    wait_hi(div_done_out, 100, "second done");
    pulse(preamble_detect_in);
    pulse(search_timer_expired_in);
    pins(1'b0, 1'b1, "preamble keeps lock");
    rd(edad_pkg::ADDR_ENERGY_RESULT, 8'h60, "true level");
    rd(edad_pkg::ADDR_ANT_ONE_ENERGY, 8'h30, "read before clear");
    @(posedge sys_clk_in);
    #1;
    div_int_clear_in = 1'b1;
    rx_int_clear_in = 1'b1;
    @(posedge sys_clk_in);
    #1;
    div_int_clear_in = 1'b0;
    rx_int_clear_in = 1'b0;
    rd(edad_pkg::ADDR_ANT_ONE_ENERGY, 8'h00, "joint clear one");
    rd(edad_pkg::ADDR_ANT_TWO_ENERGY, 8'h00, "joint clear two");
    pins(1'b1, 1'b0, "search after clear");
    // Transmit right after a false completion skips the next search
    pulse(data_detect_in);
    wait_hi(div_done_out, 100, "third done");
    pulse(search_timer_expired_in);
    wait_hi(div_false_out, 3, "second false");
    level(rx_on_in, 1'b0);
    level(tx_on_in, 1'b1);
    level(tx_on_in, 1'b0);
    level(rx_on_in, 1'b1);
    pulse(data_detect_in);
    repeat (12) @(posedge sys_clk_in);
    rd(edad_pkg::ADDR_ANT_ONE_ENERGY, 8'h00, "search skipped");
    pulse(div_int_clear_in);
    pulse(data_detect_in);
    wait_hi(div_done_out, 100, "search after skip");
    level(rx_on_in, 1'b0);
    final_report();
  end

  // ==========================================================
  // Watchdog, well past the roughly 350 cycles of the tests
  initial begin
    #20000;
    mismatches++;
    final_report();
  end
endmodule : edad_top_tb
